// [inc/cpf_pkg.sv]
// constants shared by the converter protection and fault manager
package cpf_pkg;
   // register byte offsets
   localparam logic [4:0] ADR_REPORT = 5'h00;
   localparam logic [4:0] ADR_FTYPE  = 5'h04;
   localparam logic [4:0] ADR_ILIM   = 5'h08;
   localparam logic [4:0] ADR_LIMITS = 5'h0C;
   localparam logic [4:0] ADR_FLAGS  = 5'h10;
   localparam logic [4:0] ADR_STATE  = 5'h14;
   // report_group_config_reg fields
   localparam int B_REP_EN   = 0;
   localparam int B_PROP_EN  = 1;
   localparam int B_PROP_ERR = 2;
   // fault_type_config_reg fields
   localparam int B_RAMP_DIS = 0;
   localparam int B_LATCH_LO = 1;   // latch bits 1..4: current, low volt, heat, ramp
   // current_limit_setpoint_reg fields
   localparam int B_COMP_DIS = 0;
   // limits register fields
   localparam int B_PG95     = 0;
   localparam int B_OVP_LO   = 8;
   // fault_flags_register bit positions (0 = condition present)
   localparam int F_HEATW = 0;
   localparam int F_PG    = 1;
   localparam int F_ILIM  = 2;
   localparam int F_LOWV  = 3;
   localparam int F_HEAT  = 4;
   localparam int F_RAMP  = 5;
   localparam int F_HIGHV = 6;
   localparam int NFLAG   = 7;
   // reset values
   localparam logic [31:0] RST_REPORT = 32'h0000_0000;
   localparam logic [31:0] RST_FTYPE  = 32'h0000_0000;
   localparam logic [31:0] RST_ILIM   = 32'h0000_0000;
   localparam logic [31:0] RST_LIMITS = 32'h0000_7800;  // ov at 120 %
   // thresholds, temperatures in degC, voltages in mV, ratios in percent
   localparam logic [7:0]  T_WARN_ON  = 8'd120;
   localparam logic [7:0]  T_WARN_OFF = 8'd117;
   localparam logic [7:0]  T_SHUT     = 8'd120;
   localparam logic [7:0]  T_RESTART  = 8'd110;
   localparam logic [7:0]  PCT_PG_HI  = 8'd110;
   localparam logic [7:0]  PCT_PG_LO0 = 8'd90;
   localparam logic [7:0]  PCT_PG_LO1 = 8'd95;
   localparam logic [7:0]  PCT_OV_MIN = 8'd110;
   localparam logic [7:0]  PCT_OV_MAX = 8'd130;
   localparam logic [12:0] OV_ABS_MIN = 13'd1000;
   localparam logic [12:0] RAMP_TOL   = 13'd250;
   // timing
   localparam int CLK_MHZ     = 200;
   localparam int RETRY_MS    = 130;
   localparam int RETRY_CYC   = RETRY_MS * 1000 * CLK_MHZ;
   // fsm states
   typedef enum logic [1:0] {CPF_RUN, CPF_OFF, CPF_LATCH} cpf_state_t;
endpackage : cpf_pkg

// [rtl/cpf_protect.sv]
// converter protection and fault manager with avalon-mm register access
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
module cpf_protect
   import cpf_pkg::*;
#(
   parameter int RETRY_COUNT = RETRY_CYC
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // measurements and converter phase
   input  wire logic [7:0]  temp_c,
   input  wire logic [11:0] vout_mv,
   input  wire logic [11:0] vset_mv,
   input  wire logic [11:0] vramp_mv,
   input  wire logic [11:0] prebias_mv,
   input  wire logic        ilim_hit,
   input  wire logic        ramping_up,
   input  wire logic        steady,
   input  wire logic        on_cmd,
   // power good open-drain pin
   input  wire logic        pg_pin_i,
   output logic             pg_pin_o,
   output logic             pg_pin_oe,
   // shared fault line open-drain pin
   input  wire logic        fault_line_i,
   output logic             fault_line_o,
   output logic             fault_line_oe,
   // converter control
   output logic             gate_hs_en,
   output logic             gate_ls_on,
   output logic             regular_off,
   output logic             run_en,
   output logic             ilim_comp_en,
   output logic             host_alert
);

   cpf_state_t  state;
   logic [31:0] reg_report;
   logic [31:0] reg_ftype;
   logic [31:0] reg_ilim;
   logic [31:0] reg_limits;
   logic [NFLAG-1:0] flt;        // active-high warnings and sticky faults
   logic [NFLAG-1:2] flt_q;      // sticky faults and errors, set by hardware
   logic        heat_warn;
   logic        pg_warn;
   logic        ack;
   logic [1:0]  pg_sync;
   logic [1:0]  line_sync;
   logic [1:0]  pg_oe_d;
   logic [1:0]  line_oe_d;
   logic [24:0] retry_cnt;
   logic        on_cycled;
   logic        on_prev;
   logic        hard_err;

   // v * 100 against s * pct, no divider needed
   function automatic logic pct_gt(input logic [12:0] v, input logic [11:0] s,
                                   input logic [7:0] pct);
      logic [19:0] a;
      logic [19:0] b;
      a = 20'(v) * 20'd100;
      b = 20'(s) * 20'(pct);
      return a > b;
   endfunction : pct_gt

   function automatic logic [12:0] absdiff(input logic [11:0] a, input logic [11:0] b);
      return (a > b) ? 13'(a - b) : 13'(b - a);
   endfunction : absdiff

   // register decode
   logic wr_hit;
   logic rd_hit;
   assign wr_hit = avs_write & ack;   // a write lands at the edge waitrequest is low
   assign rd_hit = avs_read & ~ack;

   // one wait state per access keeps decode and readback registered
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         ack <= 1'b0;
      else
         ack <= (avs_read | avs_write) & ~ack;
   end
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;

   // readback, unmapped offsets read zero
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_hit) begin
         unique case (avs_address)
            ADR_REPORT: avs_readdata <= reg_report;
            ADR_FTYPE:  avs_readdata <= reg_ftype;
            ADR_ILIM:   avs_readdata <= reg_ilim;
            ADR_LIMITS: avs_readdata <= reg_limits;
            ADR_FLAGS:  avs_readdata <= {25'h0, ~flt};
            ADR_STATE:  avs_readdata <= {30'h0, state};
            default:    avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // configuration registers; a flags write clears sticky faults, writes to other offsets are dropped
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         reg_report <= RST_REPORT;
         reg_ftype  <= RST_FTYPE;
         reg_ilim   <= RST_ILIM;
         reg_limits <= RST_LIMITS;
      end else if (wr_hit) begin
         if (avs_address == ADR_REPORT) reg_report <= avs_writedata;
         if (avs_address == ADR_FTYPE)  reg_ftype  <= avs_writedata;
         if (avs_address == ADR_ILIM)   reg_ilim   <= avs_writedata;
         if (avs_address == ADR_LIMITS) reg_limits <= avs_writedata;
      end
   end

   // two-flop synchronisers on both open-drain pins
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pg_sync   <= 2'b11;
         line_sync <= 2'b11;
         pg_oe_d   <= 2'b11;
         line_oe_d <= 2'b00;
      end else begin
         pg_sync   <= {pg_sync[0], pg_pin_i};
         line_sync <= {line_sync[0], fault_line_i};
         pg_oe_d   <= {pg_oe_d[0], pg_pin_oe};
         line_oe_d <= {line_oe_d[0], fault_line_oe};
      end
   end

   // threshold decisions
   logic [7:0]  ov_pct;
   logic [7:0]  pg_lo_pct;
   logic        above_pb;
   logic        pg_out;
   logic        ov_hit;
   logic        uv_hit;
   logic        ramp_err;
   logic        line_low;
   logic        ext_pg_low;
   logic        running;
   logic [12:0] vout13;

   assign vout13    = {1'b0, vout_mv};
   assign running   = (state == CPF_RUN);
   assign above_pb  = vout_mv > prebias_mv;
   assign pg_lo_pct = reg_limits[B_PG95] ? PCT_PG_LO1 : PCT_PG_LO0;
   // clamp programmed ratio into the legal span
   always_comb begin
      ov_pct = reg_limits[B_OVP_LO +: 8];
      if (ov_pct < PCT_OV_MIN) ov_pct = PCT_OV_MIN;
      if (ov_pct > PCT_OV_MAX) ov_pct = PCT_OV_MAX;
   end
   // outside 110 % or below 90/95 %
   assign pg_out = pct_gt(vout13, vset_mv, PCT_PG_HI)
                 | ~pct_gt(vout13, vset_mv, pg_lo_pct);
   // the 1.0 v floor wins over a small setpoint ratio
   assign ov_hit = above_pb & pct_gt(vout13, vset_mv, ov_pct)
                 & (vout13 > OV_ABS_MIN);
   // low-voltage threshold shares the lower window edge
   assign uv_hit   = ~pct_gt(vout13, vset_mv, pg_lo_pct);
   assign ramp_err = ramping_up & ~reg_ftype[B_RAMP_DIS]
                   & (absdiff(vout_mv, vramp_mv) > RAMP_TOL);
   // only a line pulled low by someone else counts as propagation;
   // our own pull stays masked until the synchroniser has seen its release
   assign line_low   = ~line_sync[1] & ~fault_line_oe & ~|line_oe_d;
   assign ext_pg_low = ~pg_sync[1] & ~pg_pin_oe & ~|pg_oe_d;

   // fault detection terms for this cycle
   logic set_ilim;
   logic set_lowv;
   logic set_heat;
   logic set_ramp;
   logic set_highv;
   logic fast_now;
   logic prop_fast;

   assign set_ilim  = running & above_pb & ilim_hit & uv_hit;
   assign set_lowv  = running & steady & uv_hit & ~set_ilim
                    & ~flt[F_ILIM];
   assign set_heat  = temp_c > T_SHUT;
   assign set_ramp  = running & ramp_err;
   assign set_highv = ov_hit;
   // a propagated error from the group forces the fast path
   assign prop_fast = line_low & reg_report[B_PROP_ERR];
   assign fast_now  = set_ilim | set_ramp | set_highv | prop_fast;

   // sticky faults: set beats a software clear in the same cycle
   logic [NFLAG-1:0] set_vec;
   logic [NFLAG-1:0] clr_vec;
   assign set_vec = {set_highv, set_ramp, set_heat, set_lowv, set_ilim, 2'b00};
   assign clr_vec = (wr_hit && avs_address == ADR_FLAGS) ? avs_writedata[NFLAG-1:0] : '0;

   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         flt_q <= '0;
      else
         flt_q <= set_vec[NFLAG-1:2] | (flt_q & ~clr_vec[NFLAG-1:2]);
   end

   // heat warning with hysteresis, runs whenever powered
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         heat_warn <= 1'b0;
      else if (temp_c > T_WARN_ON)
         heat_warn <= 1'b1;
      else if (temp_c < T_WARN_OFF)
         heat_warn <= 1'b0;
   end

   // power good warning follows window or external pull-down
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         pg_warn <= 1'b0;
      else if ((steady & running & pg_out) | ext_pg_low)
         pg_warn <= 1'b1;
      else
         pg_warn <= 1'b0;
   end
   // warnings sit in bits 0 and 1 below the sticky faults
   assign flt = {flt_q, pg_warn, heat_warn};

   // power good pin low on warning and whenever not steady
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         pg_pin_oe <= 1'b1;
      else
         pg_pin_oe <= (steady & running & pg_out) | ~steady | ~running;
   end
   assign pg_pin_o = 1'b0;

   // warnings reach the manager only with reporting enabled
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         host_alert <= 1'b0;
      else
         host_alert <= reg_report[B_REP_EN] & (heat_warn | pg_warn);
   end

   // shared line pulled low while a fault or error is held
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         fault_line_oe <= 1'b0;
      else
         fault_line_oe <= reg_report[B_PROP_EN] & (|flt[NFLAG-1:2]);
   end
   assign fault_line_o = 1'b0;

   // restart bookkeeping
   logic trip;
   logic cond_gone;
   logic latch_sel;
   logic retry_done;
   logic sw_cleared;

   assign trip       = (|set_vec) | line_low;
   assign retry_done = retry_cnt == 25'(RETRY_COUNT - 1);
   // heat restart waits for the lower restart temperature
   assign cond_gone  = ~uv_hit & ~ilim_hit & ~ov_hit & ~line_low
                     & (temp_c < T_RESTART);
   assign latch_sel  = |(reg_ftype[B_LATCH_LO +: 4] & flt[F_RAMP:F_ILIM]);
   assign sw_cleared = ~|flt[NFLAG-1:2];

   // remember a cycle of the turn-on command while latched
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         on_prev   <= 1'b0;
         on_cycled <= 1'b0;
      end else begin
         on_prev <= on_cmd;
         if (state != CPF_LATCH)
            on_cycled <= 1'b0;
         else if (on_cmd & ~on_prev)
            on_cycled <= 1'b1;
      end
   end

   // off-time counter measures the retry interval
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         retry_cnt <= '0;
      else if (state == CPF_RUN)
         retry_cnt <= '0;
      else if (!retry_done)
         retry_cnt <= retry_cnt + 25'd1;
   end

   // run / off / latched control
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= CPF_RUN;
      end else begin
         unique case (state)
            CPF_RUN:
               if (trip)
                  state <= CPF_OFF;
            CPF_OFF:
               if (latch_sel)
                  state <= CPF_LATCH;
               else if (retry_done & cond_gone)
                  state <= CPF_RUN;
            CPF_LATCH:
               // power cycling is the reset itself
               if (retry_done & cond_gone & (sw_cleared | on_cycled))
                  state <= CPF_RUN;
            default:
               state <= CPF_OFF;
         endcase
      end
   end
   assign run_en = on_cmd & running;

   // gate drive and turn-off mode, updated at the detecting edge
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         gate_hs_en  <= 1'b0;
         gate_ls_on  <= 1'b0;
         regular_off <= 1'b0;
         hard_err    <= 1'b0;
      end else begin
         hard_err <= set_highv | (hard_err & ~running);
         if (set_highv) begin
            gate_hs_en <= 1'b0;
            gate_ls_on <= 1'b1;
         end else if (fast_now) begin
            gate_hs_en <= 1'b0;
            gate_ls_on <= 1'b0;
         end else if (!running) begin
            gate_hs_en <= 1'b0;
            gate_ls_on <= hard_err;             // low side kept on after an over-voltage
         end else begin
            gate_hs_en <= on_cmd;
            gate_ls_on <= 1'b0;
         end
         // ramped turn-off handed to the sequencer
         regular_off <= (set_heat | set_lowv | (line_low & ~prop_fast))
                      | (regular_off & ~running) | (~running & ~hard_err);
      end
   end

   // compensation stays on unless software turns it off
   assign ilim_comp_en = ~reg_ilim[B_COMP_DIS];

endmodule : cpf_protect

// [testbench/cpf_host_model.sv]
// model of the power manager host and the rest of the converter group
`timescale 1ns/1ps
module cpf_host_model
#(
   parameter int GROUPS  = 4,  // groups one host manages at most
   parameter int MEMBERS = 32  // converters on one shared line at most
) (
   // clock and reset
   input  wire logic  clk_sys,
   input  wire logic  rst_b,
   // shared line: resolved level, our pull-down, relay request, drop count
   input  wire logic  fault_line,
   output logic       line_oe,
   input  wire logic  relay_req,
   output logic [7:0] falls,
   // error relay: front-end shutdown request
   input  wire logic  err_mode,
   output logic       front_off
);
   logic line_q;
   // another group faulted: pull this group's line low
   always_ff @(posedge clk_sys) begin
      if (!rst_b) line_oe <= 1'b0;
      else line_oe <= relay_req;
   end
   // count drops of the line, so a propagating converter is seen
   always_ff @(posedge clk_sys) begin
      line_q <= fault_line;
      if (!rst_b) falls <= 8'h00;
      else if (line_q && !fault_line) falls <= falls + 8'h01;
   end
   // a relayed error also drops the front-end supply
   always_ff @(posedge clk_sys) begin
      if (!rst_b) front_off <= 1'b0;
      else front_off <= front_off | (err_mode && !fault_line);
   end
endmodule : cpf_host_model

// [testbench/cpf_protect_sva.sv]
// assertion checker for the converter protection block
`timescale 1ns/1ps
module cpf_protect_sva
   import cpf_pkg::*;
(
   // clock, reset and register writes
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   // measurements and phase
   input wire logic [7:0]  temp_c,
   input wire logic [11:0] vout_mv,
   input wire logic [11:0] vramp_mv,
   input wire logic        ramping_up,
   input wire logic        steady,
   // pins and converter control
   input wire logic        pg_pin_i,
   input wire logic        pg_pin_oe,
   input wire logic        fault_line_i,
   input wire logic        fault_line_oe,
   input wire logic        gate_hs_en,
   input wire logic        gate_ls_on,
   input wire logic        regular_off,
   input wire logic        run_en,
   input wire logic        host_alert
);
   logic        rep_en;
   logic        ramp_dis;
   logic [11:0] ramp_err;
   // distance between output and ramp target, either sign
   assign ramp_err = (vout_mv > vramp_mv) ? vout_mv - vramp_mv : vramp_mv - vout_mv;
   // shadow of two enables, taken at the edge that completes a write
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rep_en   <= 1'b0;
         ramp_dis <= 1'b0;
      end else if (avs_write && !avs_waitrequest) begin
         if (avs_address == ADR_REPORT) rep_en <= avs_writedata[B_REP_EN];
         if (avs_address == ADR_FTYPE) ramp_dis <= avs_writedata[B_RAMP_DIS];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // both switches released together
   sequence s_fast_off;
      !gate_hs_en && !gate_ls_on;
   endsequence
   // a pull on the pin that the block itself is not making
   sequence s_pg_pulled;
      (!pg_pin_i && !pg_pin_oe && steady && rep_en) [*6];
   endsequence
   heat_alert_a: assert property (temp_c > T_WARN_ON && rep_en |-> ##[1:3] host_alert)
      else $error("heat warning not reported");
   quiet_alert_a: assert property (!rep_en [*3] |-> !host_alert)
      else $error("alert raised with reporting off");
   pg_transit_a: assert property (!steady |-> ##[1:2] pg_pin_oe)
      else $error("power good released outside steady state");
   pg_pulled_a: assert property (s_pg_pulled |-> host_alert)
      else $error("outside pull on power good not reported");
   heat_stop_a: assert property (temp_c > T_SHUT |=> !run_en)
      else $error("still running above shutdown temperature");
   ramp_trip_a: assert property (ramping_up && !ramp_dis && ramp_err > RAMP_TOL |=> s_fast_off)
      else $error("ramp error did not drop both switches");
   line_off_a: assert property ((!fault_line_i && !fault_line_oe) [*4] |-> regular_off || !gate_hs_en)
      else $error("low shared line did not start turn-off");
   no_shoot_a: assert property (gate_ls_on |-> !gate_hs_en)
      else $error("both switches on together");
endmodule : cpf_protect_sva

bind cpf_protect cpf_protect_sva u_cpf_protect_sva (
   .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .temp_c(temp_c),
   .vout_mv(vout_mv), .vramp_mv(vramp_mv), .ramping_up(ramping_up), .steady(steady),
   .pg_pin_i(pg_pin_i), .pg_pin_oe(pg_pin_oe), .fault_line_i(fault_line_i), .fault_line_oe(fault_line_oe),
   .gate_hs_en(gate_hs_en),
   .gate_ls_on(gate_ls_on), .regular_off(regular_off), .run_en(run_en), .host_alert(host_alert)
);

// [testbench/test_cpf_protect.sv]
// self-checking bench for the converter protection block
`timescale 1ns/1ps
module test_cpf_protect
   import cpf_pkg::*;
;
   localparam int RETRY = 50;  // short retry interval keeps the run brief
   logic        clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, ilim_hit, ramping_up, steady;
   logic        pg_pin_oe, fault_line_oe, gate_hs_en, gate_ls_on, regular_off, run_en, ilim_comp_en;
   logic        host_alert, ext_pg, relay_req, host_oe, on_cmd, err_mode, front_off;
   logic [4:0]  avs_address;
   logic [7:0]  temp_c, falls;
   logic [11:0] vout_mv, prebias_mv;
   logic [31:0] avs_writedata, avs_readdata, rd_val;
   int          fails = 0, checks_done = 0, cycles = 0;
   wire         pg_pin, fault_line;
   // open-drain wires with pull-ups: low while any party pulls
   assign pg_pin = !(pg_pin_oe || ext_pg);
   assign fault_line = !(fault_line_oe || host_oe);
   cpf_protect #(.RETRY_COUNT(RETRY)) u_cpf_protect (.clk_sys(clk_sys), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .temp_c(temp_c), .vout_mv(vout_mv),
      .vset_mv(12'd1000), .vramp_mv(12'd500), .prebias_mv(prebias_mv), .ilim_hit(ilim_hit),
      .ramping_up(ramping_up), .steady(steady), .on_cmd(on_cmd), .pg_pin_i(pg_pin), .pg_pin_o(),
      .pg_pin_oe(pg_pin_oe), .fault_line_i(fault_line), .fault_line_o(), .fault_line_oe(fault_line_oe),
      .gate_hs_en(gate_hs_en), .gate_ls_on(gate_ls_on), .regular_off(regular_off), .run_en(run_en),
      .ilim_comp_en(ilim_comp_en), .host_alert(host_alert));
   cpf_host_model u_cpf_host_model (.clk_sys(clk_sys), .rst_b(rst_b), .fault_line(fault_line),
      .line_oe(host_oe), .relay_req(relay_req), .falls(falls), .err_mode(err_mode), .front_off(front_off));
   // 200 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // hang guard, well above the roughly one thousand cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   // one avalon transfer; the request stands until waitrequest is seen low
   task automatic xfer(input logic rnw, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= rnw;
      avs_write     <= !rnw;
      @(posedge clk_sys);
      while (avs_waitrequest) @(posedge clk_sys);
      rd_val = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : xfer
   // read a register and compare one field of it
   task automatic rc(input string what, input logic [4:0] a, input int b, input logic [31:0] e);
      xfer(1'b1, a, 32'h0000_0000);
      chk(what, (a == ADR_STATE) ? rd_val : 32'(rd_val[b]), e);
   endtask : rc
   // healthy steady-state inputs
   task automatic nominal();
      temp_c     <= 8'd25;
      vout_mv    <= 12'd1000;
      ilim_hit   <= 1'b0;
      ramping_up <= 1'b0;
      steady     <= 1'b1;
      ext_pg     <= 1'b0;
      relay_req  <= 1'b0;
      on_cmd     <= 1'b1;
      prebias_mv <= 12'd0;
      err_mode   <= 1'b0;
   endtask : nominal
   // remove the cause, clear sticky flags, wait out the retry interval
   task automatic recover();
      nominal();
      cyc(4);
      xfer(1'b0, ADR_FLAGS, 32'h0000_007f);
      cyc(RETRY + 10);
      rc("restart", ADR_STATE, 0, 32'h0000_0000);
   endtask : recover
   initial begin
      rst_b         = 1'b0;
      avs_address   = 5'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0000_0000;
      nominal();
      cyc(20);
      rst_b <= 1'b1;
      // reset values, then an unmapped word that ignores writes
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, 5'(4 * i), 32'h0000_0000);
         chk("reset value", rd_val, (i == 3) ? RST_LIMITS : (i == 2) ? RST_ILIM : (i == 1) ? RST_FTYPE : RST_REPORT);
      end
      xfer(1'b0, 5'h18, 32'hffff_ffff);
      rc("unmapped", 5'h18, 0, 32'h0000_0000);
      // heat: warning unreported, then reported; shutdown and restart below 110
      temp_c <= 8'd121;
      cyc(5);
      chk("alert off", host_alert, 1'b0);
      chk("ramped off", {regular_off, run_en}, 2'b10);
      rc("heat warn", ADR_FLAGS, F_HEATW, 1'b0);
      rc("heat shut", ADR_FLAGS, F_HEAT, 1'b0);
      xfer(1'b0, ADR_REPORT, 32'h0000_0001);
      cyc(4);
      chk("alert on", host_alert, 1'b1);
      temp_c <= 8'd118;
      cyc(5);
      rc("warn held", ADR_FLAGS, F_HEATW, 1'b0);
      temp_c <= 8'd116;
      cyc(RETRY + 10);
      rc("warn gone", ADR_FLAGS, F_HEATW, 1'b1);
      rc("still off", ADR_STATE, 0, 32'h0000_0001);
      recover();
      // power good above 110 percent, then 930 mV against the 90 and 95 limits
      vout_mv <= 12'd1120;
      cyc(5);
      chk("pg over", {pg_pin_oe, host_alert}, 2'b11);
      rc("pg flag", ADR_FLAGS, F_PG, 1'b0);
      vout_mv <= 12'd930;
      cyc(5);
      chk("pg back", pg_pin_oe, 1'b0);
      rc("pg 90", ADR_FLAGS, F_PG, 1'b1);
      xfer(1'b0, ADR_LIMITS, RST_LIMITS | 32'h0000_0001);
      cyc(5);
      chk("lowv ramped", regular_off, 1'b1);
      rc("low volt", ADR_FLAGS, F_LOWV, 1'b0);
      xfer(1'b0, ADR_LIMITS, RST_LIMITS);
      recover();
      // in transition the pin is held and low voltage is ignored
      steady  <= 1'b0;
      vout_mv <= 12'd500;
      cyc(5);
      chk("pg transit", pg_pin_oe, 1'b1);
      rc("no lowv", ADR_FLAGS, F_LOWV, 1'b1);
      recover();
      ext_pg <= 1'b1;
      cyc(7);
      chk("ext alert", host_alert, 1'b1);
      recover();
      // ramp following: 250 mV passes, 260 mV trips unless disabled
      for (int k = 0; k < 2; k++) begin
         xfer(1'b0, ADR_FTYPE, 32'(k));
         steady     <= 1'b0;
         ramping_up <= 1'b1;
         vout_mv    <= 12'd750;
         cyc(5);
         rc("ramp 250", ADR_FLAGS, F_RAMP, 1'b1);
         vout_mv <= 12'd760;
         cyc(4);
         rc("ramp 260", ADR_FLAGS, F_RAMP, 32'(k));
         recover();
      end
      xfer(1'b0, ADR_FTYPE, 32'h0000_0000);
      // over-voltage against a 130 percent limit, propagated on the shared line
      xfer(1'b0, ADR_REPORT, 32'h0000_0003);
      xfer(1'b0, ADR_LIMITS, 32'h0000_8200);
      vout_mv <= 12'd1290;
      cyc(5);
      rc("ov 130", ADR_FLAGS, F_HIGHV, 1'b1);
      prebias_mv <= 12'd1400;
      vout_mv    <= 12'd1310;
      cyc(4);
      rc("ov prebias", ADR_FLAGS, F_HIGHV, 1'b1);
      prebias_mv <= 12'd0;
      vout_mv <= 12'd1310;
      cyc(4);
      chk("ov gates", {gate_hs_en, gate_ls_on}, 2'b01);
      chk("line pulled", {fault_line_oe, falls != 8'h00}, 2'b11);
      rc("ov flag", ADR_FLAGS, F_HIGHV, 1'b0);
      xfer(1'b0, ADR_LIMITS, RST_LIMITS);
      recover();
      // current limit under the low-voltage threshold, compensation off
      xfer(1'b0, ADR_ILIM, 32'h0000_0001);
      cyc(1);
      chk("comp off", ilim_comp_en, 1'b0);
      steady   <= 1'b0;
      ilim_hit <= 1'b1;
      vout_mv  <= 12'd800;
      cyc(3);
      chk("ilim gates", {gate_hs_en, gate_ls_on}, 2'b00);
      rc("ilim flag", ADR_FLAGS, F_ILIM, 1'b0);
      xfer(1'b0, ADR_ILIM, 32'h0000_0000);
      recover();
      // relayed line drop, handled first as a fault, then as an error
      relay_req <= 1'b1;
      cyc(6);
      chk("relay ramped", {regular_off, front_off}, 2'b10);
      recover();
      xfer(1'b0, ADR_REPORT, 32'h0000_0007);
      relay_req <= 1'b1;
      err_mode  <= 1'b1;
      cyc(6);
      chk("relay fast", {gate_hs_en, gate_ls_on, front_off}, 3'b001);
      recover();
      // latching heat shutdown stays off until the turn-on command is cycled
      xfer(1'b0, ADR_FTYPE, 32'h0000_0008);
      temp_c <= 8'd121;
      cyc(5);
      rc("latched", ADR_STATE, 0, 32'h0000_0002);
      temp_c <= 8'd100;
      cyc(RETRY + 10);
      rc("latch held", ADR_STATE, 0, 32'h0000_0002);
      on_cmd <= 1'b0;
      cyc(2);
      on_cmd <= 1'b1;
      cyc(3);
      rc("on cycled", ADR_STATE, 0, 32'h0000_0000);
      recover();
      summarize();
   end
endmodule : test_cpf_protect
